/* File: rtl/tcc_channels.v */
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
`include "tcc_defines.vh"

module tcc_channels
(
	input  wire        core_clk,          // Bus clock, 250 MHz
	input  wire        reset,             // Synchronous reset, high
	input  wire [7:0]  regAddr,           // Register byte address
	input  wire [7:0]  regWrData,         // Register write data
	input  wire        regWr,             // Write strobe
	input  wire        regRd,             // Read strobe
	output wire [7:0]  regRdData,         // Read data, cycle after strobe
	input  wire [15:0] counterValue,      // Shared 16-bit counter
	input  wire        counterOverflow,   // Counter rollover pulse
	input  wire        counterStop,       // Counter stop level
	input  wire        counterReset,      // Counter reset pulse
	input  wire [1:0]  chPinIn,           // Channel pins, asynchronous
	output wire [1:0]  chPinOut,          // Channel pin drive level
	output wire [1:0]  chPinOe_n,         // Pin enable, low drives
	output wire [1:0]  irqReq             // Per-channel interrupt request
);

	// ----------------------------------------------------------------
	// Shared state
	// ----------------------------------------------------------------
	reg  [7:0]  rdData_q;                 // Registered read data
	reg         bufMode_q;                // Buffered mode, channel 0 only
	reg         pendSel_q;                // Pair last completed by software
	reg         activeSel_q;              // Pair used as compare value
	wire [31:0] chValue;                  // Both value pairs
	wire [15:0] rdSlice;                  // Read contributions per channel
	wire        ch0LoWr;                  // Channel 0 low byte write
	wire        ch1LoWr;                  // Channel 1 low byte write
	wire        sc0Wr;                    // Channel 0 control write

	assign ch0LoWr = regWr && (regAddr == `TCC_ADDR_CH0L);
	assign ch1LoWr = regWr && (regAddr == `TCC_ADDR_CH1L);
	assign sc0Wr   = regWr && (regAddr == `TCC_ADDR_SC0);
	assign regRdData = rdData_q;

	// ----------------------------------------------------------------
	// Buffered mode select and pair steering
	// ----------------------------------------------------------------

	// Buffer bit lives only in the channel 0 control byte
	always @(posedge core_clk)
	begin
		if (reset)
		begin
			bufMode_q <= `TCC_RST_BIT;
		end
		else if (sc0Wr)
		begin
			bufMode_q <= regWrData[`TCC_BIT_BUF];
		end
	end

	// Completed low-byte write marks the pair to use next
	always @(posedge core_clk)
	begin
		if (reset)
		begin
			pendSel_q <= `TCC_RST_BIT;
		end
		else if (ch1LoWr)
		begin
			pendSel_q <= 1'b1;
		end
		else if (ch0LoWr)
		begin
			pendSel_q <= 1'b0;
		end
	end

	// Swap only at a period boundary, so a half-written pair never matches
	always @(posedge core_clk)
	begin
		if (reset)
		begin
			activeSel_q <= `TCC_RST_BIT;
		end
		else if (counterOverflow || counterReset)
		begin
			activeSel_q <= pendSel_q;
		end
	end

	// ----------------------------------------------------------------
	// Read data register
	// ----------------------------------------------------------------

	// Data stand only in the cycle after the strobe, zero otherwise
	always @(posedge core_clk)
	begin
		if (reset)
		begin
			rdData_q <= `TCC_RST_BYTE;
		end
		else if (regRd)
		begin
			rdData_q <= rdSlice[7:0] | rdSlice[15:8];
		end
		else
		begin
			rdData_q <= `TCC_RST_BYTE;
		end
	end

	// ----------------------------------------------------------------
	// Per-channel logic
	// ----------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < 2; i = i + 1)
		begin : g_ch
			localparam [7:0] SC_ADDR = (i == 0) ? `TCC_ADDR_SC0  : `TCC_ADDR_SC1;
			localparam [7:0] HI_ADDR = (i == 0) ? `TCC_ADDR_CH0H : `TCC_ADDR_CH1H;
			localparam [7:0] LO_ADDR = (i == 0) ? `TCC_ADDR_CH0L : `TCC_ADDR_CH1L;

			reg        flag_q;            // Channel event flag
			reg        armed_q;           // Flag seen set by a status read
			reg        ie_q;              // Channel interrupt enable
			reg        msa_q;             // Mode select A
			reg  [1:0] els_q;             // Edge/level select
			reg        tov_q;             // Toggle on overflow
			reg        max_q;             // Max duty force, as written
			reg        maxEff_q;          // Max duty, applied this period
			reg  [7:0] valHi_q;           // Value high byte
			reg  [7:0] valLo_q;           // Value low byte
			reg        capBlock_q;        // Captures held off
			reg        cmpBlock_q;        // Compares held off
			reg        matchPrev_q;       // Match seen last cycle
			reg  [2:0] sync_q;            // Pin synchroniser chain
			reg        pinLvl_q;          // Last agreed pin level
			reg        outLvl_q;          // Channel output state
			reg        oeN_q;             // Pin enable, low drives
			reg        irq_q;             // Interrupt request
			reg  [7:0] rd;                // Read contribution

			wire       scOff;             // Control register disabled
			wire       bufSel;            // This channel runs buffered
			wire       scWr;              // Control write
			wire       scRd;              // Control read
			wire       hiWr;              // High byte write
			wire       loWr;              // Low byte write
			wire       hiRd;              // High byte read
			wire       loRd;              // Low byte read
			wire       modeZero;          // Mode bits both zero
			wire       capMode;           // Input capture active
			wire       cmpMode;           // Output compare or PWM active
			wire       stable;            // Second and third stage agree
			wire       rise;              // Qualified rising edge
			wire       fall;              // Qualified falling edge
			wire       edgeHit;           // Selected edge seen
			wire       capEvt;            // Capture taken
			wire [15:0] cmpVal;           // Value compared against
			wire       matchNow;          // Counter equals compare value
			wire       cmpEvt;            // Compare event, one pulse
			wire       ovfAct;            // Overflow toggle due
			wire       evt;               // Any channel event

			// Channel 1 shuts down while channel 0 runs buffered
			assign scOff    = (i == 1) && bufMode_q;
			assign bufSel   = (i == 0) && bufMode_q;
			assign scWr     = regWr && (regAddr == SC_ADDR) && !scOff;
			assign scRd     = regRd && (regAddr == SC_ADDR) && !scOff;
			assign hiWr     = regWr && (regAddr == HI_ADDR);
			assign loWr     = regWr && (regAddr == LO_ADDR);
			assign hiRd     = regRd && (regAddr == HI_ADDR);
			assign loRd     = regRd && (regAddr == LO_ADDR);
			assign modeZero = !bufSel && !msa_q;

			// Mode decode: edge field off means no mode at all
			assign capMode = (els_q != `TCC_ELS_OFF) && modeZero && !scOff;
			assign cmpMode = (els_q != `TCC_ELS_OFF) && !modeZero && !scOff;

			// Edge found only once the later stages agree, filtering glitches
			assign stable = (sync_q[1] == sync_q[2]);
			assign rise   = stable && sync_q[2] && !pinLvl_q;
			assign fall   = stable && !sync_q[2] && pinLvl_q;
			assign edgeHit = capMode &&
				(((els_q == `TCC_ELS_RISE) && rise) ||
				 ((els_q == `TCC_ELS_FALL) && fall) ||
				 ((els_q == `TCC_ELS_ANY) && (rise || fall)));
			assign capEvt = edgeHit && !counterStop && !capBlock_q;

			// Buffered channel 0 compares against the active pair
			if (i == 0)
			begin : g_sel
				assign cmpVal = bufMode_q ? (activeSel_q ? chValue[31:16] : chValue[15:0])
				                          : {valHi_q, valLo_q};
			end
			else
			begin : g_own
				assign cmpVal = {valHi_q, valLo_q};
			end

			// Counter may sit on one value for many clocks; pulse once
			assign matchNow = cmpMode && (counterValue == cmpVal) && !cmpBlock_q;
			assign cmpEvt   = matchNow && !matchPrev_q;
			assign ovfAct   = cmpMode && tov_q && counterOverflow;
			assign evt      = capEvt || cmpEvt;
			assign chValue[i*16 +: 16] = {valHi_q, valLo_q};

			// Pin synchroniser, first stage read by the second only
			always @(posedge core_clk)
			begin
				if (reset)
				begin
					sync_q   <= `TCC_RST_SYNC;
					pinLvl_q <= `TCC_RST_BIT;
				end
				else
				begin
					sync_q <= {sync_q[1:0], chPinIn[i]};
					if (stable)
					begin
						pinLvl_q <= sync_q[2];
					end
				end
			end

			// Control fields; disabled register ignores writes
			always @(posedge core_clk)
			begin
				if (reset)
				begin
					ie_q  <= `TCC_RST_BIT;
					msa_q <= `TCC_RST_BIT;
					els_q <= `TCC_RST_ELS;
					tov_q <= `TCC_RST_BIT;
					max_q <= `TCC_RST_BIT;
				end
				else if (scWr)
				begin
					ie_q  <= regWrData[`TCC_BIT_IE];
					msa_q <= regWrData[`TCC_BIT_MSA];
					els_q <= regWrData[`TCC_BIT_ELSH:`TCC_BIT_ELSL];
					tov_q <= regWrData[`TCC_BIT_TOV];
					max_q <= regWrData[`TCC_BIT_MAX];
				end
			end

			// Event flag: set wins over clear, writing one does nothing
			always @(posedge core_clk)
			begin
				if (reset)
				begin
					flag_q <= `TCC_RST_BIT;
				end
				else if (evt)
				begin
					flag_q <= 1'b1;
				end
				else if (scWr && !regWrData[`TCC_BIT_FLAG] && armed_q)
				begin
					flag_q <= 1'b0;
				end
			end

			// Clear sequence: a new event disarms, so the zero write misses
			always @(posedge core_clk)
			begin
				if (reset)
				begin
					armed_q <= `TCC_RST_BIT;
				end
				else if (evt)
				begin
					armed_q <= 1'b0;
				end
				else if (scRd && flag_q)
				begin
					armed_q <= 1'b1;
				end
				else if (scWr)
				begin
					armed_q <= 1'b0;
				end
			end

			// Value pair: capture loads it, software writes byte-wise
			always @(posedge core_clk)
			begin
				if (reset)
				begin
					valHi_q <= `TCC_RST_BYTE;
					valLo_q <= `TCC_RST_BYTE;
				end
				else if (capEvt)
				begin
					valHi_q <= counterValue[15:8];
					valLo_q <= counterValue[7:0];
				end
				else
				begin
					if (hiWr)
					begin
						valHi_q <= regWrData;
					end
					if (loWr)
					begin
						valLo_q <= regWrData;
					end
				end
			end

			// Half-read and half-written pairs hold off events
			always @(posedge core_clk)
			begin
				if (reset)
				begin
					capBlock_q <= `TCC_RST_BIT;
					cmpBlock_q <= `TCC_RST_BIT;
				end
				else
				begin
					if (loRd)
					begin
						capBlock_q <= 1'b0;
					end
					else if (hiRd && modeZero)
					begin
						capBlock_q <= 1'b1;
					end
					if (loWr)
					begin
						cmpBlock_q <= 1'b0;
					end
					else if (hiWr && !modeZero)
					begin
						cmpBlock_q <= 1'b1;
					end
				end
			end

			// Match history; counter reset restarts edge finding
			always @(posedge core_clk)
			begin
				if (reset || counterReset)
				begin
					matchPrev_q <= `TCC_RST_BIT;
				end
				else
				begin
					matchPrev_q <= matchNow;
				end
			end

			// Max duty sampled at period start, so it lags one period
			always @(posedge core_clk)
			begin
				if (reset)
				begin
					maxEff_q <= `TCC_RST_BIT;
				end
				else if (counterOverflow || counterReset)
				begin
					maxEff_q <= max_q;
				end
			end

			// Output state; overflow toggle has priority over compare
			always @(posedge core_clk)
			begin
				if (reset)
				begin
					outLvl_q <= `TCC_RST_LEVEL;
				end
				else if (els_q == `TCC_ELS_OFF)
				begin
					outLvl_q <= !msa_q;
				end
				else if (cmpMode)
				begin
					if (ovfAct)
					begin
						outLvl_q <= !outLvl_q;
					end
					else if (maxEff_q && !tov_q)
					begin
						outLvl_q <= 1'b1;
					end
					else if (cmpEvt)
					begin
						case (els_q)
							`TCC_ELS_TOGGLE: outLvl_q <= !outLvl_q;
							`TCC_ELS_CLEAR:  outLvl_q <= 1'b0;
							`TCC_ELS_SET:    outLvl_q <= 1'b1;
							default:         outLvl_q <= outLvl_q;
						endcase
					end
				end
			end

			// Pin driven only in compare modes; else left to port logic
			always @(posedge core_clk)
			begin
				if (reset)
				begin
					oeN_q <= `TCC_RST_OE_N;
				end
				else
				begin
					oeN_q <= !cmpMode;
				end
			end

			// Interrupt request gated by the enable
			always @(posedge core_clk)
			begin
				if (reset)
				begin
					irq_q <= `TCC_RST_BIT;
				end
				else
				begin
					irq_q <= ie_q && flag_q && !scOff;
				end
			end

			// Read contribution; disabled control byte reads zero
			always @*
			begin
				rd = `TCC_RST_BYTE;
				if (scRd)
				begin
					rd = {flag_q, ie_q, bufSel, msa_q, els_q, tov_q, max_q};
				end
				else if (hiRd)
				begin
					rd = valHi_q;
				end
				else if (loRd)
				begin
					rd = valLo_q;
				end
			end

			assign rdSlice[i*8 +: 8] = rd;
			assign chPinOut[i]       = outLvl_q;
			assign chPinOe_n[i]      = oeN_q;
			assign irqReq[i]         = irq_q;
		end
	endgenerate

endmodule // tcc_channels

/* File: rtl/tcc_defines.vh */
`ifndef TCC_DEFINES_VH
`define TCC_DEFINES_VH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define TCC_ADDR_SC0      8'h45
`define TCC_ADDR_CH0H     8'h46
`define TCC_ADDR_CH0L     8'h47
`define TCC_ADDR_SC1      8'h48
`define TCC_ADDR_CH1H     8'h49
`define TCC_ADDR_CH1L     8'h4A

// ----------------------------------------------------------------
// Status and control field positions
// ----------------------------------------------------------------
`define TCC_BIT_FLAG      7
`define TCC_BIT_IE        6
`define TCC_BIT_BUF       5
`define TCC_BIT_MSA       4
`define TCC_BIT_ELSH      3
`define TCC_BIT_ELSL      2
`define TCC_BIT_TOV       1
`define TCC_BIT_MAX       0

// ----------------------------------------------------------------
// Edge/level encodings
// ----------------------------------------------------------------
`define TCC_ELS_OFF       2'h0
`define TCC_ELS_RISE      2'h1
`define TCC_ELS_FALL      2'h2
`define TCC_ELS_ANY       2'h3
`define TCC_ELS_TOGGLE    2'h1
`define TCC_ELS_CLEAR     2'h2
`define TCC_ELS_SET       2'h3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define TCC_RST_BIT       1'h0
`define TCC_RST_ELS       2'h0
`define TCC_RST_BYTE      8'h00
`define TCC_RST_SYNC      3'h0
`define TCC_RST_LEVEL     1'h1
`define TCC_RST_OE_N      1'h1

`endif

/* File: test/tcc_channels_sva.sv */
`timescale 1ns/1ps
`include "tcc_defines.vh"
// ----------------------------------------------------------------
// Port checker
// ----------------------------------------------------------------
module tcc_channels_chk
(
	input wire       core_clk,  // Bus clock
	input wire       reset,     // Sync reset
	input wire [7:0] regAddr,   // Address
	input wire       regWr,     // Write strobe
	input wire       regRd,     // Read strobe
	input wire [7:0] regRdData, // Read data
	input wire [1:0] chPinOut,  // Pin level
	input wire [1:0] chPinOe_n, // Pin enable
	input wire [1:0] irqReq     // Requests
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	// Status reads; data shows one cycle later
	sequence s_rd0; regRd && regAddr == `TCC_ADDR_SC0; endsequence
	sequence s_rd1; regRd && regAddr == `TCC_ADDR_SC1; endsequence
	property p_rst_out; $past(reset) |-> chPinOe_n == 2'h3 && chPinOut == 2'h3 && irqReq == 2'h0; endproperty
	a_rst_out: assert property (p_rst_out) else $error("outputs wrong after reset");
	property p_flag_rst; $past(reset) && regRd && regAddr == `TCC_ADDR_SC0 |=> !regRdData[7]; endproperty
	a_flag_rst: assert property (p_flag_rst) else $error("flag set after reset");
	// A write in the cycle before may have changed flag or enable
	property p_irq_src; regRd && regAddr == `TCC_ADDR_SC0 && irqReq[0] && !$past(regWr) |=> regRdData[7:6] == 2'h3;
	endproperty
	a_irq_src: assert property (p_irq_src) else $error("request without flag and enable");
	property p_irq_set; s_rd0 ##1 regRdData[7:6] == 2'h3 |-> irqReq[0]; endproperty
	a_irq_set: assert property (p_irq_set) else $error("request missing");
	property p_off_pin; s_rd0 ##1 regRdData[3:2] == 2'h0 |-> chPinOe_n[0]; endproperty
	a_off_pin: assert property (p_off_pin) else $error("pin driven with edge field off");
	property p_off_lvl; s_rd0 ##1 regRdData[3:2] == 2'h0 |-> chPinOut[0] == !regRdData[4]; endproperty
	a_off_lvl: assert property (p_off_lvl) else $error("initial level wrong");
	property p_cap_pin; s_rd0 ##1 regRdData[5:4] == 2'h0 |-> chPinOe_n[0]; endproperty
	a_cap_pin: assert property (p_cap_pin) else $error("pin driven in capture mode");
	property p_buf_bit; s_rd1 |=> !regRdData[5]; endproperty
	a_buf_bit: assert property (p_buf_bit) else $error("buffered bit seen on channel 1");
	property p_buf_off; s_rd0 ##1 regRdData[5] && regRd && regAddr == `TCC_ADDR_SC1 |=> regRdData == 8'h00; endproperty
	a_buf_off: assert property (p_buf_off) else $error("channel 1 control visible while buffered");
endmodule // tcc_channels_chk

bind tcc_channels tcc_channels_chk tcc_channels_chk_inst (.core_clk(core_clk), .reset(reset), .regAddr(regAddr),
	.regWr(regWr), .regRd(regRd), .regRdData(regRdData), .chPinOut(chPinOut), .chPinOe_n(chPinOe_n), .irqReq(irqReq));

/* File: test/tcc_pin_model.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Pin side of both channels
// ----------------------------------------------------------------
module tcc_pin_model
(
	input  wire [1:0] pinOut,   // Channel drive level
	input  wire [1:0] pinOe_n,  // Low while channel drives
	input  wire [1:0] extLevel, // Level the port side drives
	output wire [1:0] pinLevel  // Resolved pin level
);
	// No pull on these pins; the port side drives whenever the channel lets go
	assign pinLevel[0] = pinOe_n[0] ? extLevel[0] : pinOut[0];
	assign pinLevel[1] = pinOe_n[1] ? extLevel[1] : pinOut[1];
endmodule // tcc_pin_model

/* File: test/test_tcc_channels.sv */
`timescale 1ns/1ps
`include "tcc_defines.vh"
`define CHK(a,b) begin check_count++; if ((a) !== (b)) begin fails++; $display("Error at %0t: got %h want %h", $time, a, b); end end
module test_tcc_channels;
	// ----------------------------------------------------------------
	// Stimulus and wiring
	// ----------------------------------------------------------------
	logic        core_clk, reset = 1'b1, regWr = 1'b0, regRd = 1'b0, rdDly = 1'b0;
	logic        counterOverflow = 1'b0, counterStop = 1'b0, counterReset = 1'b0; // Counter controls, idle low
	logic [7:0]  regAddr = 8'h00, regWrData = 8'h00, c, e8, m8;
	logic [15:0] counterValue = 16'h0000, V;
	logic [1:0]  ext = 2'h1;                // Port side levels, defined from time zero
	logic        o;                         // Expected compare output
	wire  [7:0]  regRdData;
	wire  [1:0]  chPinOut, chPinOe_n, irqReq, pinLevel;
	logic [7:0]  expQ[$], mskQ[$];          // Expected read data and care mask
	int          fails = 0, check_count = 0, els;

	tcc_channels tcc_channels_inst (.core_clk(core_clk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
		.regWr(regWr), .regRd(regRd), .regRdData(regRdData), .counterValue(counterValue),
		.counterOverflow(counterOverflow), .counterStop(counterStop), .counterReset(counterReset),
		.chPinIn(pinLevel), .chPinOut(chPinOut), .chPinOe_n(chPinOe_n), .irqReq(irqReq));
	tcc_pin_model tcc_pin_model_inst (.pinOut(chPinOut), .pinOe_n(chPinOe_n), .extLevel(ext), .pinLevel(pinLevel));

	initial
	begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	// ----------------------------------------------------------------
	// Bus tasks; strobes stay up so reads can run back to back
	// ----------------------------------------------------------------
	task nop(input int n); regRd <= 1'b0; regWr <= 1'b0; repeat (n) @(posedge core_clk); endtask
	task wr(input [7:0] a, d); regRd <= 1'b0; regWr <= 1'b1; regAddr <= a; regWrData <= d; @(posedge core_clk); endtask
	task rd(input [7:0] a, e, m);
		regWr <= 1'b0; regRd <= 1'b1; regAddr <= a;
		expQ.push_back(e);
		mskQ.push_back(m);
		@(posedge core_clk);
	endtask
	// Arm by reading, then write zero to the flag
	task clr(input [7:0] a, d); rd(a, d, 8'h7F); wr(a, d); rd(a, d, 8'hFF); endtask
	// Optional match on V and optional overflow pulse in one cycle
	task tick(input logic m, ov);
		if (m) counterValue <= V;
		counterOverflow <= ov;
		nop(1);
		counterOverflow <= 1'b0;
		counterValue <= V + 16'h1;
		nop(2);
	endtask
	task wrap_up;
		$display("Mismatches %0d, comparisons %0d", fails, check_count);
		if (fails == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Read data lands one cycle after the strobe; oldest note is compared
	always @(posedge core_clk)
	begin
		if (rdDly)
		begin
			e8 = expQ.pop_front();
			m8 = mskQ.pop_front();
			`CHK(regRdData & m8, e8 & m8)
		end
		rdDly <= regRd;
	end

	// Hang guard
	initial
	begin
		repeat (20000) @(posedge core_clk);
		fails++;
		wrap_up;
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		void'($urandom(57620));
		repeat (12) @(posedge core_clk);
		reset <= 1'b0;
		rd(`TCC_ADDR_SC0, 8'h00, 8'hFF);
		rd(`TCC_ADDR_SC1, 8'h00, 8'hFF);
		rd(8'h40, 8'h00, 8'hFF);
		// Capture on channel 1; pin held low long before enabling
		for (els = 1; els < 4; els++)
		begin
			c = {4'h4, els[1:0], 2'h0};
			wr(`TCC_ADDR_SC1, c);
			V = 16'($urandom);
			counterValue <= V;
			ext[1] <= 1'b1;
			nop(6);
			rd(`TCC_ADDR_SC1, {els[0], c[6:0]}, 8'hFF);
			rd(`TCC_ADDR_CH1H, V[15:8], {8{els[0]}});
			rd(`TCC_ADDR_CH1L, V[7:0], {8{els[0]}});
			nop(1);
			`CHK(irqReq[1], els[0])
			clr(`TCC_ADDR_SC1, c);
			ext[1] <= 1'b0;
			nop(6);
			rd(`TCC_ADDR_SC1, {els[1], c[6:0]}, 8'hFF);
			clr(`TCC_ADDR_SC1, c);
		end
		// Both edges while the counter is stopped
		counterStop <= 1'b1;
		ext[1] <= 1'b1;
		nop(6);
		ext[1] <= 1'b0;
		nop(6);
		rd(`TCC_ADDR_SC1, c, 8'hFF);
		counterStop <= 1'b0;
		// High byte read holds the value until the low byte is read
		rd(`TCC_ADDR_CH1H, V[15:8], 8'hFF);
		counterValue <= ~V;
		ext[1] <= 1'b1;
		nop(6);
		rd(`TCC_ADDR_CH1L, V[7:0], 8'hFF);
		rd(`TCC_ADDR_CH1H, V[15:8], 8'hFF);
		// Compare on channel 0, starting from a low preset
		V = 16'($urandom);
		wr(`TCC_ADDR_CH0H, V[15:8]);
		wr(`TCC_ADDR_CH0L, V[7:0]);
		wr(`TCC_ADDR_SC0, 8'h10);
		nop(2);
		`CHK(chPinOut[0], 1'b0)
		`CHK(pinLevel[0], 1'b1)
		o = 1'b0;
		for (els = 1; els < 4; els++)
		begin
			c = {4'h5, els[1:0], 2'h0};
			wr(`TCC_ADDR_SC0, c);
			tick(1'b1, 1'b0);
			o = (els == 1) ? !o : els[0];
			rd(`TCC_ADDR_SC0, {1'b1, c[6:0]}, 8'hFF);
			`CHK(pinLevel[0], o)
			clr(`TCC_ADDR_SC0, c);
		end
		wr(`TCC_ADDR_CH0H, V[15:8]);
		tick(1'b1, 1'b0);
		rd(`TCC_ADDR_SC0, c, 8'hFF);
		wr(`TCC_ADDR_CH0L, V[7:0]);
		tick(1'b1, 1'b0);
		rd(`TCC_ADDR_SC0, {1'b1, c[6:0]}, 8'hFF);
		tick(1'b1, 1'b0);
		wr(`TCC_ADDR_SC0, c);
		rd(`TCC_ADDR_SC0, {1'b1, c[6:0]}, 8'hFF);
		clr(`TCC_ADDR_SC0, c);
		wr(`TCC_ADDR_SC0, {1'b1, c[6:0]});
		rd(`TCC_ADDR_SC0, c, 8'hFF);
		// Toggle on overflow with a clearing compare action
		wr(`TCC_ADDR_SC0, 8'h5A);
		tick(1'b0, 1'b1);
		`CHK(chPinOut[0], 1'b0)
		tick(1'b1, 1'b1);
		`CHK(chPinOut[0], 1'b1)
		// Full duty applies only from the next period on
		wr(`TCC_ADDR_SC0, 8'h59);
		tick(1'b1, 1'b0);
		`CHK(chPinOut[0], 1'b0)
		tick(1'b0, 1'b1);
		`CHK(chPinOut[0], 1'b1)
		tick(1'b1, 1'b0);
		`CHK(chPinOut[0], 1'b1)
		wr(`TCC_ADDR_SC0, 8'h58);
		tick(1'b1, 1'b0);
		`CHK(chPinOut[0], 1'b1)
		tick(1'b0, 1'b1);
		tick(1'b1, 1'b0);
		`CHK(chPinOut[0], 1'b0)
		// Buffered mode hides channel 1 and swaps pairs at overflow
		wr(`TCC_ADDR_SC1, 8'h54);
		// Counter stopped and reset around the function change
		counterStop <= 1'b1;
		counterReset <= 1'b1;
		nop(1);
		counterReset <= 1'b0;
		wr(`TCC_ADDR_SC0, 8'h2C);
		counterStop <= 1'b0;
		rd(`TCC_ADDR_SC0, 8'h2C, 8'h7F);
		rd(`TCC_ADDR_SC1, 8'h00, 8'hFF);
		wr(`TCC_ADDR_SC1, 8'h44);
		rd(`TCC_ADDR_SC1, 8'h00, 8'hFF);
		nop(1);
		`CHK(chPinOe_n[1], 1'b1)
		V = 16'($urandom);
		wr(`TCC_ADDR_CH1H, V[15:8]);
		wr(`TCC_ADDR_CH1L, V[7:0]);
		clr(`TCC_ADDR_SC0, 8'h2C);
		tick(1'b0, 1'b1);
		tick(1'b1, 1'b0);
		rd(`TCC_ADDR_SC0, 8'hAC, 8'hFF);
		// Counter reset brings the newly written pair 0 in at once
		clr(`TCC_ADDR_SC0, 8'h2C);
		V = ~V;
		wr(`TCC_ADDR_CH0H, V[15:8]);
		wr(`TCC_ADDR_CH0L, V[7:0]);
		counterReset <= 1'b1;
		nop(1);
		counterReset <= 1'b0;
		tick(1'b1, 1'b0);
		rd(`TCC_ADDR_SC0, 8'hAC, 8'hFF);
		nop(3);
		wrap_up;
	end
endmodule // test_tcc_channels
